/* logic/mmdia_map.svh */
// Offsets, field positions, encodings, reset values and timing counts of the window logic
//
// Function
// - Control bits 4:0 select the device space
// - Selector 11111 reaches the general extended space
// - Selector 00001 reaches the PMA device space
// - Selector 00011 reaches the vendor device space
// - Window accesses under other selectors are ignored
// - Control bits 15:14 hold the access function
// - Address function: window reaches the address register
// - Data function 01: access, address unchanged
// - Function 10: increment after reads and writes
// - Function 11: increment after writes only
// - Address-mode window writes keep overwriting the address
// - Address-mode window reads return the address
// - Non-incrementing writes keep rewriting one register
// - Non-incrementing reads keep returning one register
// - Incrementing writes target successive higher addresses
// - Both registers sit in the direct 32-register set
`ifndef MMDIA_MAP_SVH
`define MMDIA_MAP_SVH

// ----------------------------------------------------------------
// Direct register offsets
// ----------------------------------------------------------------
`define MMDIA_OFS_CTRL 5'h0D
`define MMDIA_OFS_WINDOW 5'h0E

// ----------------------------------------------------------------
// Control register field positions
// ----------------------------------------------------------------
`define MMDIA_SEL_MSB 4
`define MMDIA_SEL_LSB 0
`define MMDIA_FUNC_MSB 15
`define MMDIA_FUNC_LSB 14

// ----------------------------------------------------------------
// Selector and function encodings
// ----------------------------------------------------------------
`define MMDIA_SEL_GENERAL 5'h1F
`define MMDIA_SEL_PMA 5'h01
`define MMDIA_SEL_VENDOR 5'h03
`define MMDIA_FUNC_ADDR 2'h0
`define MMDIA_FUNC_DATA 2'h1
`define MMDIA_FUNC_INC_RW 2'h2
`define MMDIA_FUNC_INC_WR 2'h3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define MMDIA_CTRL_RESET 16'h0000
`define MMDIA_ADDR_RESET 16'h0000
`define MMDIA_RDATA_RESET 16'h0000

// ----------------------------------------------------------------
// Timing: longest wait for the extended space to answer
// ----------------------------------------------------------------
`define MMDIA_CLK_PERIOD_NS 10
`define MMDIA_ACK_TIMEOUT_NS 2560
`define MMDIA_ACK_TIMEOUT_CYC ((`MMDIA_ACK_TIMEOUT_NS) / (`MMDIA_CLK_PERIOD_NS))

`endif

/* logic/mmdia_pkg.sv */
// Types shared by the extended register window logic
package mmdia_pkg;

  // Device space reached by a data access
  typedef enum logic [1:0] {
    SPACE_GENERAL,
    SPACE_PMA,
    SPACE_VENDOR
  } mmdia_space_t;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_EXT
  } mmdia_state_t;

  // Direct register request from the management frame engine
  typedef struct packed {
    logic valid;
    logic write;
    logic [4:0] addr;
    logic [15:0] wdata;
  } mmdia_mgmt_req_t;

  // Request towards the extended register spaces
  typedef struct packed {
    logic valid;
    logic write;
    mmdia_space_t space;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mmdia_ext_req_t;

endpackage : mmdia_pkg

/* logic/mmdia_addr_ptr.sv */
// Extended-space address register with load and post increment
`timescale 1ns/1ns
`include "mmdia_map.svh"
module mmdia_addr_ptr
  import mmdia_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Update controls
  input wire logic load_in,
  input wire logic [ADDR_W-1:0] load_value_in,
  input wire logic inc_in,
  // Current address
  output logic [ADDR_W-1:0] addr_out
);

  logic [ADDR_W-1:0] addr_reg;

  // Load wins over increment; otherwise the value is held
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      addr_reg <= ADDR_W'(`MMDIA_ADDR_RESET);
    end else if (load_in) begin
      addr_reg <= load_value_in;
    end else if (inc_in) begin
      addr_reg <= addr_reg + ADDR_W'(1);
    end
  end

  assign addr_out = addr_reg;

endmodule : mmdia_addr_ptr

/* logic/mmdia_window.sv */
// Control register and address/data window giving indirect access to extended spaces
`timescale 1ns/1ns
`include "mmdia_map.svh"
module mmdia_window
  import mmdia_pkg::*;
#(
  parameter int DATA_W = 16,
  parameter int ACK_TIMEOUT_CYC = `MMDIA_ACK_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Direct register access from the frame engine
  input wire mmdia_mgmt_req_t mgmt_req_in,
  output logic mgmt_ack_out,
  output logic [DATA_W-1:0] mgmt_rdata_out,
  // Extended register space port
  output mmdia_ext_req_t ext_req_out,
  input wire logic ext_ack_in,
  input wire logic [DATA_W-1:0] ext_rdata_in,
  // Status
  output logic ext_timeout_out,
  output logic busy_out
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------

  // True for the three supported selector values
  function automatic logic sel_valid(input logic [4:0] sel);
    sel_valid = (sel == `MMDIA_SEL_GENERAL) || (sel == `MMDIA_SEL_PMA) ||
                (sel == `MMDIA_SEL_VENDOR);
  endfunction : sel_valid

  // Maps a supported selector to its device space
  function automatic mmdia_space_t sel_space(input logic [4:0] sel);
    case (sel)
      `MMDIA_SEL_PMA: sel_space = SPACE_PMA;
      `MMDIA_SEL_VENDOR: sel_space = SPACE_VENDOR;
      default: sel_space = SPACE_GENERAL;
    endcase
  endfunction : sel_space

  // True when the function asks for a post increment of this access
  function automatic logic want_inc(input logic [1:0] func, input logic write);
    case (func)
      `MMDIA_FUNC_INC_RW: want_inc = 1'b1;
      `MMDIA_FUNC_INC_WR: want_inc = write;
      default: want_inc = 1'b0;
    endcase
  endfunction : want_inc

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------

  mmdia_state_t state_reg;
  logic [1:0] func_reg;
  logic [4:0] sel_reg;
  logic inc_pend_reg;
  logic req_write_reg;
  logic [15:0] tmo_cnt_reg;
  logic mgmt_ack_reg;
  logic [DATA_W-1:0] mgmt_rdata_reg;
  mmdia_ext_req_t ext_req_reg;
  logic ext_timeout_reg;

  logic [15:0] ptr_addr;
  logic [DATA_W-1:0] ctrl_view;
  logic req_take;
  logic hit_ctrl;
  logic hit_win;
  logic hit_other;
  logic win_ok;
  logic win_ignored;
  logic win_addr_fn;
  logic win_data;
  logic ext_done;
  logic ext_to;
  logic ptr_load;
  logic ptr_inc;

  localparam logic [15:0] TMO_LAST = 16'(ACK_TIMEOUT_CYC - 1);

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------

  // A request is taken only while no extended access is outstanding
  assign req_take = (state_reg == ST_IDLE) && mgmt_req_in.valid;
  assign hit_ctrl = req_take && (mgmt_req_in.addr == `MMDIA_OFS_CTRL);
  assign hit_win = req_take && (mgmt_req_in.addr == `MMDIA_OFS_WINDOW);
  assign hit_other = req_take && !hit_ctrl && !hit_win;

  // Window accesses under an unsupported selector do nothing
  assign win_ok = hit_win && sel_valid(sel_reg);
  assign win_ignored = hit_win && !sel_valid(sel_reg);
  assign win_addr_fn = win_ok && (func_reg == `MMDIA_FUNC_ADDR);
  assign win_data = win_ok && (func_reg != `MMDIA_FUNC_ADDR);

  // Extended access completion and time-out
  assign ext_done = (state_reg == ST_EXT) && ext_ack_in;
  assign ext_to = (state_reg == ST_EXT) && !ext_ack_in && (tmo_cnt_reg == TMO_LAST);

  // Address register updates
  assign ptr_load = win_addr_fn && mgmt_req_in.write;
  assign ptr_inc = ext_done && inc_pend_reg;

  // Control register as read back; reserved bits read zero
  assign ctrl_view = DATA_W'({func_reg, 9'h000, sel_reg});

  // ----------------------------------------------------------------
  // Address register
  // ----------------------------------------------------------------

  mmdia_addr_ptr #(
    .ADDR_W(16)
  ) u_addr_ptr (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .load_in(ptr_load),
    .load_value_in(mgmt_req_in.wdata),
    .inc_in(ptr_inc),
    .addr_out(ptr_addr)
  );

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------

  // A write takes effect for the very next window access
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      func_reg <= 2'(`MMDIA_CTRL_RESET >> `MMDIA_FUNC_LSB);
      sel_reg <= 5'(`MMDIA_CTRL_RESET >> `MMDIA_SEL_LSB);
    end else if (hit_ctrl && mgmt_req_in.write) begin
      func_reg <= mgmt_req_in.wdata[`MMDIA_FUNC_MSB:`MMDIA_FUNC_LSB];
      sel_reg <= mgmt_req_in.wdata[`MMDIA_SEL_MSB:`MMDIA_SEL_LSB];
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------

  // Idle until a data access is sent out, then wait for its answer
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (win_data) begin
            state_reg <= ST_EXT;
          end
        end
        ST_EXT: begin
          if (ext_done || ext_to) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Increment decision and direction captured when the access starts
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      inc_pend_reg <= 1'b0;
      req_write_reg <= 1'b0;
    end else if (win_data) begin
      inc_pend_reg <= want_inc(func_reg, mgmt_req_in.write);
      req_write_reg <= mgmt_req_in.write;
    end
  end

  // Cycles spent waiting for the extended space
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tmo_cnt_reg <= 16'h0000;
    end else if (state_reg == ST_EXT) begin
      tmo_cnt_reg <= tmo_cnt_reg + 16'h0001;
    end else begin
      tmo_cnt_reg <= 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // Extended space request
  // ----------------------------------------------------------------

  // Held from issue until the answer or the time-out
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ext_req_reg <= '0;
    end else if (win_data) begin
      ext_req_reg.valid <= 1'b1;
      ext_req_reg.write <= mgmt_req_in.write;
      ext_req_reg.space <= sel_space(sel_reg);
      ext_req_reg.addr <= ptr_addr;
      ext_req_reg.wdata <= mgmt_req_in.wdata;
    end else if (ext_done || ext_to) begin
      ext_req_reg.valid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Answer to the frame engine
  // ----------------------------------------------------------------

  // One-cycle acknowledge for every taken request
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mgmt_ack_reg <= 1'b0;
    end else begin
      mgmt_ack_reg <= hit_ctrl || hit_other || win_ignored || win_addr_fn ||
                      ext_done || ext_to;
    end
  end

  // Read data; writes and ignored accesses answer zero
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mgmt_rdata_reg <= DATA_W'(`MMDIA_RDATA_RESET);
    end else if (hit_ctrl && !mgmt_req_in.write) begin
      mgmt_rdata_reg <= ctrl_view;
    end else if (win_addr_fn && !mgmt_req_in.write) begin
      mgmt_rdata_reg <= DATA_W'(ptr_addr);
    end else if (ext_done && !req_write_reg) begin
      mgmt_rdata_reg <= ext_rdata_in;
    end else if (req_take || ext_done || ext_to) begin
      mgmt_rdata_reg <= DATA_W'(`MMDIA_RDATA_RESET);
    end
  end

  // One-cycle flag when the extended space failed to answer
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ext_timeout_reg <= 1'b0;
    end else begin
      ext_timeout_reg <= ext_to;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  assign mgmt_ack_out = mgmt_ack_reg;
  assign mgmt_rdata_out = mgmt_rdata_reg;
  assign ext_req_out = ext_req_reg;
  assign ext_timeout_out = ext_timeout_reg;
  assign busy_out = ext_req_reg.valid;

endmodule : mmdia_window

/* verification/mmdia_window_properties.sv */
// Concurrent checks on the extended register window ports
`timescale 1ns/1ns
module mmdia_window_checker
  import mmdia_pkg::*;
#(
  parameter int DATA_W = 16,
  parameter int ACK_TIMEOUT_CYC = 256
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Frame engine side
  input wire mmdia_mgmt_req_t mgmt_req_in,
  input wire logic mgmt_ack_out,
  input wire logic [DATA_W-1:0] mgmt_rdata_out,
  // Extended space side
  input wire mmdia_ext_req_t ext_req_out,
  input wire logic ext_ack_in,
  input wire logic [DATA_W-1:0] ext_rdata_in,
  // Status
  input wire logic ext_timeout_out,
  input wire logic busy_out
);
  localparam int TMAX = ACK_TIMEOUT_CYC;
  logic [6:0] ctrl_reg;
  logic take;
  logic sel_ok;
  logic [1:0] fn;
  // Taken requests and the shadowed control fields
  assign take = mgmt_req_in.valid && !busy_out;
  assign fn = ctrl_reg[6:5];
  assign sel_ok = ctrl_reg[4:0] inside {5'h1F, 5'h01, 5'h03};
  // Shadow of function and selector as last written
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_reg <= 7'h00;
    end else if (take && mgmt_req_in.write && mgmt_req_in.addr == 5'h0D) begin
      ctrl_reg <= {mgmt_req_in.wdata[15:14], mgmt_req_in.wdata[4:0]};
    end
  end
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);
  // Steps of a window access
  sequence s_win;
    take && mgmt_req_in.addr == 5'h0E;
  endsequence
  sequence s_ext_done;
    ext_req_out.valid && ext_ack_in;
  endsequence
  chk_busy_level: assert property ($fell(busy_out) |-> mgmt_ack_out)
    else $error("extended access ended without acknowledge");
  chk_local_ack: assert property (take && mgmt_req_in.addr != 5'h0E |=> mgmt_ack_out)
    else $error("direct register access not acknowledged");
  chk_ctrl_read: assert property (take && !mgmt_req_in.write && mgmt_req_in.addr == 5'h0D
    |=> mgmt_rdata_out == {ctrl_reg[6:5], 9'h000, ctrl_reg[4:0]})
    else $error("control read value wrong");
  chk_bad_sel: assert property (s_win ##0 !sel_ok
    |=> mgmt_ack_out && mgmt_rdata_out == 16'h0000 && !ext_req_out.valid)
    else $error("window access under bad selector not ignored");
  chk_addr_local: assert property (s_win ##0 sel_ok && fn == 2'h0
    |=> mgmt_ack_out && !ext_req_out.valid)
    else $error("address function reached extended space");
  chk_space_map: assert property (s_win ##0 sel_ok && fn != 2'h0
    |=> ext_req_out.valid && ext_req_out.write == $past(mgmt_req_in.write)
      && ext_req_out.space == (ctrl_reg[4:0] == 5'h1F ? SPACE_GENERAL :
      ctrl_reg[4:0] == 5'h01 ? SPACE_PMA : SPACE_VENDOR))
    else $error("extended request space or direction wrong");
  chk_req_stable: assert property (ext_req_out.valid ##1 ext_req_out.valid
    |-> $stable(ext_req_out))
    else $error("extended request changed while pending");
  chk_ext_answer: assert property (s_ext_done ##0 !ext_req_out.write
    |=> mgmt_ack_out && !ext_req_out.valid && mgmt_rdata_out == $past(ext_rdata_in))
    else $error("extended read data not returned");
  chk_ext_bound: assert property ($rose(ext_req_out.valid)
    |-> ##[1:TMAX] !ext_req_out.valid)
    else $error("extended request outlived its time limit");
endmodule : mmdia_window_checker

bind mmdia_window mmdia_window_checker #(.DATA_W(DATA_W), .ACK_TIMEOUT_CYC(ACK_TIMEOUT_CYC))
  u_chk (.mclk_in, .rst_n_in, .mgmt_req_in, .mgmt_ack_out, .mgmt_rdata_out, .ext_req_out,
  .ext_ack_in, .ext_rdata_in, .ext_timeout_out, .busy_out);

/* verification/mmdia_ext_model.sv */
// Behavioural extended register spaces answering window requests
`timescale 1ns/1ns
module mmdia_ext_model
  import mmdia_pkg::*;
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Request and answer
  input wire mmdia_ext_req_t req_in,
  input wire logic [3:0] lat_in,
  output logic ack_out,
  output logic [15:0] rdata_out
);
  logic [15:0] mem_reg [0:3][0:15];
  logic [3:0] wait_reg;
  // One file per space, answer after lat_in waiting cycles
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_out <= 1'b0;
      rdata_out <= 16'h0000;
      wait_reg <= 4'h0;
      mem_reg <= '{default: 16'h0000};
    end else if (req_in.valid && !ack_out && wait_reg == lat_in) begin
      ack_out <= 1'b1;
      rdata_out <= mem_reg[req_in.space][req_in.addr[3:0]];
      wait_reg <= 4'h0;
      if (req_in.write) begin
        mem_reg[req_in.space][req_in.addr[3:0]] <= req_in.wdata;
      end
    end else begin
      ack_out <= 1'b0;
      rdata_out <= ~rdata_out; // Data not held outside the answer
      wait_reg <= (req_in.valid && !ack_out) ? wait_reg + 4'h1 : 4'h0;
    end
  end
endmodule : mmdia_ext_model

/* verification/mmd_indirect_register_access_tb.sv */
// Self-checking bench for the extended register window
`timescale 1ns/1ns
module mmd_indirect_register_access_tb;
  import mmdia_pkg::*;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  mmdia_mgmt_req_t req = '0;
  mmdia_ext_req_t ext_req;
  logic ack, ext_ack, tmo, busy;
  logic [15:0] rdata, ext_rdata, got;
  logic got_tmo;
  logic [3:0] lat = 4'h0;
  int mismatches = 0;
  int n_compared = 0;
  // Free running clock
  always #5 mclk_in = ~mclk_in;
  mmdia_window #(.DATA_W(16), .ACK_TIMEOUT_CYC(4)) DUT (.mclk_in(mclk_in),
    .rst_n_in(rst_n_in), .mgmt_req_in(req), .mgmt_ack_out(ack), .mgmt_rdata_out(rdata),
    .ext_req_out(ext_req), .ext_ack_in(ext_ack), .ext_rdata_in(ext_rdata),
    .ext_timeout_out(tmo), .busy_out(busy));
  mmdia_ext_model u_ext (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .req_in(ext_req),
    .lat_in(lat), .ack_out(ext_ack), .rdata_out(ext_rdata));
  // Verdict and end of run
  task results();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results
  // One direct register access, bounded wait for the acknowledge
  task acc(input logic w, input logic [4:0] a, input logic [15:0] d);
    int i;
    @(posedge mclk_in) req <= '{1'b1, w, a, d};
    @(posedge mclk_in) req.valid <= 1'b0;
    #1;
    for (i = 0; i < 20 && ack !== 1'b1; i++) begin
      @(posedge mclk_in);
      #1;
    end
    got = rdata;
    got_tmo = tmo;
    if (ack !== 1'b1) begin
      mismatches++;
      $display("wrong value ack exp 1 got %b", ack);
      results();
    end
  endtask : acc
  // Compare the time-out flag seen with the last acknowledge
  task tchk(input logic e);
    n_compared++;
    if (got_tmo !== e) begin
      mismatches++;
      $display("wrong value ext_timeout exp %b got %b", e, got_tmo);
    end
  endtask : tchk
  // Read and compare
  task rd(input logic [4:0] a, input logic [15:0] e);
    acc(1'b0, a, 16'h0000);
    n_compared++;
    if (got !== e) begin
      mismatches++;
      $display("wrong value reg %h exp %h got %h", a, e, got);
    end
  endtask : rd
  task cw(input logic [15:0] d);
    acc(1'b1, 5'h0D, d);
  endtask : cw
  task ww(input logic [15:0] d);
    acc(1'b1, 5'h0E, d);
  endtask : ww
  task wrd(input logic [15:0] e);
    rd(5'h0E, e);
  endtask : wrd
  // Main sequence
  initial begin
    repeat (12) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    rd(5'h0D, 16'h0000);
    ww(16'h1234);
    cw(16'hFFFF);
    rd(5'h0D, 16'hC01F);
    cw(16'h001F);
    wrd(16'h0000);
    ww(16'h0005);
    ww(16'h0007);
    wrd(16'h0007);
    wrd(16'h0007);
    cw(16'h401F);
    ww(16'hAAAA);
    ww(16'hBBBB);
    wrd(16'hBBBB);
    wrd(16'hBBBB);
    cw(16'h801F);
    ww(16'h1111);
    ww(16'h2222);
    wrd(16'h0000);
    cw(16'h001F);
    wrd(16'h000A);
    cw(16'hC01F);
    ww(16'h3333);
    wrd(16'h0000);
    wrd(16'h0000);
    cw(16'h001F);
    wrd(16'h000B);
    ww(16'h0007);
    cw(16'h401F);
    wrd(16'h1111);
    cw(16'h0001);
    ww(16'h0008);
    cw(16'h4001);
    wrd(16'h0000);
    ww(16'h4444);
    cw(16'h8001);
    wrd(16'h4444);
    cw(16'h0001);
    wrd(16'h0009);
    cw(16'h0003);
    ww(16'h0008);
    cw(16'h4003);
    ww(16'h5555);
    wrd(16'h5555);
    cw(16'h401F);
    @(posedge mclk_in) lat <= 4'h2;
    wrd(16'h2222);
    tchk(1'b0);
    cw(16'h4002);
    ww(16'h9999);
    wrd(16'h0000);
    cw(16'h401F);
    wrd(16'h2222);
    @(posedge mclk_in) lat <= 4'hF;
    cw(16'h801F);
    wrd(16'h0000);
    tchk(1'b1);
    @(posedge mclk_in) lat <= 4'h0;
    cw(16'h001F);
    wrd(16'h0008);
    acc(1'b1, 5'h05, 16'hFFFF);
    rd(5'h05, 16'h0000);
    results();
  end
endmodule : mmd_indirect_register_access_tb
